/* File: sep_pkg.sv */
`default_nettype none
package sep_pkg;

	// Clock and write cycle timing.
	localparam int CLK_PERIOD_NS = 20;
	localparam int WRITE_TIME_NS = 3000000;
	// Longest write time, rounded down to whole cycles.
	localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W       = 18;

	// Array geometry.
	localparam int ADDR_W     = 15;
	localparam int OFS_W      = 6;
	localparam int PAGE_BYTES = 64;
	localparam int MEM_BYTES  = 32768;
	localparam int BYTE_BITS  = 8;

	// Address word type codes, lock select word-address bit and lock data bit.
	localparam logic [3:0] TYPE_ARRAY  = 4'ha;
	localparam logic [3:0] TYPE_IDPAGE = 4'hb;
	localparam int         LOCK_SEL_BIT  = 10;
	localparam int         LOCK_DATA_BIT = 1;

	// Write staging buffer.
	localparam int FIFO_DEPTH = 16;

	// Reset values.
	localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEV,
		ST_AHI,
		ST_ALO,
		ST_WDAT,
		ST_RDAT,
		ST_DRAIN,
		ST_SWEEP,
		ST_WAIT
	} sep_state_t;

	// One staged write byte: offset inside the page and the data.
	typedef struct packed {
		logic [OFS_W-1:0]     ofs;
		logic [BYTE_BITS-1:0] data;
	} sep_ent_t;

	typedef struct packed {
		sep_state_t           st;
		logic [2:0]           sclSync;
		logic [2:0]           sdaSync;
		logic [1:0]           wpSync;
		logic [2:0]           cs1;
		logic [2:0]           cs2;
		logic [3:0]           cnt;
		logic                 ackPh;
		logic                 mack;
		logic                 rdMode;
		logic [7:0]           sh;
		logic                 sdaOe;
		logic                 sdaOut;
		logic [ADDR_W-1:0]    addr;
		logic                 idSel;
		logic                 wrote;
		logic                 lockPend;
		logic                 locked;
		logic [PAGE_BYTES-1:0] mask;
		logic [OFS_W-1:0]     sweep;
		logic [TIMER_W-1:0]   timer;
		logic                 standby;
		logic                 busy;
	} sep_regs_t;

	// Clock and data synchronisers start at the idle-high bus level, so no false edge follows.
	localparam sep_regs_t REGS_RST = '{
		st: ST_IDLE,
		sclSync: 3'h7,
		sdaSync: 3'h7,
		addr: ADDR_RST,
		standby: 1'b1,
		default: '0
	};

endpackage : sep_pkg
`default_nettype wire

/* File: sep_eeprom_slave.sv */
// Summary of operation
// R1: Match three received chip-select bits against the three strapped pins.
// R2: An unconnected chip-select pin counts as low.
// R3: Data line is only pulled low, released for high.
// R4: Sample data on clock rise, change outgoing bits after clock fall.
// R5: Write-protect high blocks array writes; low allows normal access.
// R6: Array is 512 pages of 64 bytes, 15-bit word address.
// R7: Data changes only with clock low; changes with clock high are conditions.
// R8: Data falling with clock high is start and opens a new transfer.
// R9: Data rising with clock high is stop; after reads it gives standby.
// R10: Words are 8 bits; device pulls data low on the ninth clock.
// R11: Standby at power-up and after stop once internal work ends.
// R12: Controller recovers with up to 9 clocks, then a start.
// R13: Address word is type code 1010, three chip selects, then direction.
// R14: Direction bit high means read, low means write.
// R15: Matching address is acknowledged; mismatch returns to standby silently.
// R16: Byte write is two address bytes, one data byte, then stop starts programming.
// R17: During programming inputs are ignored and the bus gets no answer.
// R18: Page write allows up to 63 more data bytes, each acknowledged.
// R19: Writes advance only the low six address bits, wrapping in the page.
// R20: Identification page write uses type 1011, bit 10 zero, low six bits offset.
// R21: Locked identification page refuses data bytes and stays unchanged.
// R22: Polling during programming gets an acknowledge only once it has ended.
// R23: Programming time runs from the stop that ends the write.
// R24: Type 1011, bit 10 one, data bit 1 one locks the page forever.
// R25: Address counter keeps last address plus one; reads start there.
// R26: Protected array writes start no programming and change nothing.
// R27: Address high byte comes first; its top bit is ignored.
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO; depth must be a power of two.
module sep_fifo
	import sep_pkg::*;
#(
	parameter int Width = 14,
	parameter int Depth = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [Width-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [Width-1:0] outData
);
	localparam int AW = $clog2(Depth);

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} sep_fptr_t;

	sep_fptr_t        r;
	sep_fptr_t        next_r;
	logic [Width-1:0] store [Depth];

	// Full when the pointers differ only in the wrap bit.
	assign inReady  = (r.wr ^ r.rd) != {1'b1, {AW{1'b0}}};
	assign outValid = r.wr != r.rd;
	assign outData  = store[r.rd[AW-1:0]];

	// Pointer advance on each accepted push and pop.
	always_comb begin
		next_r = r;
		if (inValid && inReady) begin
			next_r.wr = r.wr + 1'b1;
		end
		if (outValid && outReady) begin
			next_r.rd = r.rd + 1'b1;
		end
	end

	// Pointer registers.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// Storage has no reset; only written entries are ever read.
	always_ff @(posedge clk) begin
		if (inValid && inReady) begin
			store[r.wr[AW-1:0]] <= inData;
		end
	end
endmodule : sep_fifo

module sep_eeprom_slave
	import sep_pkg::*;
#(
	parameter int WriteCycles = WRITE_CYCLES,
	parameter int FifoDepth   = FIFO_DEPTH
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic sclPin,
	input  wire logic sdaIn,
	input  wire logic chipSelectBit2,
	input  wire logic chipSelectBit1,
	input  wire logic chipSelectBit0,
	input  wire logic writeProtect,
	output logic      sdaOut,
	output logic      sdaOe,
	output logic      standby,
	output logic      writeBusy,
	output logic      idLocked
);
	sep_regs_t            r;
	sep_regs_t            next_r;
	logic [7:0]           arrayMem [MEM_BYTES];
	logic [7:0]           idMem    [PAGE_BYTES];
	logic [7:0]           pageBuf  [PAGE_BYTES];
	logic                 sclRise;
	logic                 sclFall;
	logic                 startSeen;
	logic                 stopSeen;
	logic                 devHit;
	logic [7:0]           rdByte;
	logic                 push;
	sep_ent_t             pushEnt;
	logic                 fifoReady;
	logic                 popValid;
	logic                 popReady;
	sep_ent_t             popEnt;
	logic                 ack;

	// Edges and bus conditions use only the second and third sync stages.
	assign sclRise   = r.sclSync[1] & ~r.sclSync[2]; // R4
	assign sclFall   = ~r.sclSync[1] & r.sclSync[2]; // R4
	// Data moving while the clock stays high is a condition, not a bit.
	assign startSeen = r.sclSync[1] & r.sclSync[2]
		& r.sdaSync[2] & ~r.sdaSync[1]; // R7 R8
	assign stopSeen  = r.sclSync[1] & r.sclSync[2]
		& ~r.sdaSync[2] & r.sdaSync[1]; // R7 R9

	// Address word match: either type code and the strapped selects.
	assign devHit = (r.sh[7:4] == TYPE_ARRAY || r.sh[7:4] == TYPE_IDPAGE)
		&& r.sh[3:1] == r.cs2; // R1 R13

	// Byte at the address counter, from the array or the ID page.
	assign rdByte = r.idSel ? idMem[r.addr[OFS_W-1:0]]
		: arrayMem[r.addr]; // R6 R25

	// Staged bytes drain into the page buffer except during the sweep.
	assign popReady = r.st != ST_SWEEP;

	sep_fifo #(
		.Width ($bits(sep_ent_t)),
		.Depth (FifoDepth)
	) u_fifo (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.inValid  (push),
		.inReady  (fifoReady),
		.inData   (pushEnt),
		.outValid (popValid),
		.outReady (popReady),
		.outData  (popEnt)
	);

	// Next state of the whole slave.
	always_comb begin
		next_r  = r;
		push    = 1'b0;
		pushEnt = '0;
		ack     = 1'b0;
		// Two stages before use, a third only for edge finding.
		next_r.sclSync = {r.sclSync[1:0], sclPin};
		next_r.sdaSync = {r.sdaSync[1:0], sdaIn};
		next_r.wpSync  = {r.wpSync[0], writeProtect};
		// Pads bias floating selects low, so only a driven high reads 1.
		next_r.cs1 = {chipSelectBit2, chipSelectBit1, chipSelectBit0}; // R2
		next_r.cs2 = r.cs1;
		if (popValid && popReady) begin
			next_r.mask[popEnt.ofs] = 1'b1;
		end
		if (r.st == ST_DRAIN || r.st == ST_SWEEP || r.st == ST_WAIT) begin
			// Programming: the bus is ignored entirely, polls get no ack.
			next_r.timer = r.timer + 1'b1; // R17 R22 R23
			if (r.st == ST_DRAIN && !popValid) begin
				next_r.st    = ST_SWEEP;
				next_r.sweep = '0;
			end else if (r.st == ST_SWEEP) begin
				next_r.sweep = r.sweep + 1'b1;
				if (r.sweep == OFS_W'(PAGE_BYTES - 1)) begin
					next_r.st   = ST_WAIT;
					next_r.mask = '0;
				end
			end else if (r.st == ST_WAIT
				&& r.timer >= TIMER_W'(WriteCycles - 1)) begin
				next_r.st       = ST_IDLE; // R11
				next_r.locked   = r.locked | r.lockPend; // R24
				next_r.lockPend = 1'b0;
			end
		end else if (startSeen) begin
			// A start outside programming opens a fresh transfer and drops unsent writes.
			next_r.st       = ST_DEV; // R8
			next_r.cnt      = '0;
			next_r.ackPh    = 1'b0;
			next_r.sdaOe    = 1'b0;
			next_r.wrote    = 1'b0;
			next_r.lockPend = 1'b0;
			next_r.mask     = '0;
		end else if (stopSeen) begin
			next_r.cnt   = '0;
			next_r.ackPh = 1'b0;
			next_r.sdaOe = 1'b0;
			next_r.timer = '0; // R23
			next_r.wrote = 1'b0;
			// Stop after a staged byte or a lock byte with bit 1 set starts programming, else standby.
			next_r.st = r.wrote ? ST_DRAIN : ST_IDLE; // R9 R16 R26
		end else if (r.st != ST_IDLE) begin
			if (sclRise) begin
				if (r.ackPh) begin
					// Controller answer on the ninth clock of a read byte.
					next_r.mack = ~r.sdaSync[1];
				end else if (r.cnt < 4'h8) begin
					next_r.cnt = r.cnt + 4'h1;
					next_r.sh  = {r.sh[6:0],
						r.st == ST_RDAT ? 1'b0 : r.sdaSync[1]}; // R4
				end
			end else if (sclFall) begin
				if (!r.ackPh && r.cnt == 4'h8) begin
					next_r.ackPh = 1'b1;
					if (r.st == ST_RDAT) begin
						// Let go so the controller can answer.
						next_r.sdaOe = 1'b0;
					end else begin
						unique case (r.st)
							ST_DEV: begin
								ack           = devHit; // R15
								next_r.idSel  = r.sh[4];
								next_r.rdMode = r.sh[0]; // R14
							end
							ST_AHI: begin
								ack = 1'b1;
								// Top bit of the high byte is dropped.
								next_r.addr[14:8] = r.sh[6:0]; // R27
							end
							ST_ALO: begin
								ack              = 1'b1;
								next_r.addr[7:0] = r.sh;
							end
							ST_WDAT: begin
								if (r.idSel && r.addr[LOCK_SEL_BIT]) begin
									ack = ~r.locked; // R24
									if (ack && r.sh[LOCK_DATA_BIT]) begin
										next_r.lockPend = 1'b1; // R24
										next_r.wrote    = 1'b1;
									end
								end else begin
									// Protected or locked targets refuse data.
									ack = (r.idSel ? ~r.locked
										: ~r.wpSync[1]) & fifoReady; // R5 R20 R21 R26
									push = ack;
								end
								if (push) begin
									pushEnt.ofs  = r.addr[OFS_W-1:0]; // R20
									pushEnt.data = r.sh;
									next_r.wrote = 1'b1; // R18
									next_r.addr[OFS_W-1:0] =
										r.addr[OFS_W-1:0] + 1'b1; // R19
								end
							end
							default: begin
								ack = 1'b0;
							end
						endcase
						// Acknowledge by pulling low through the ninth clock.
						next_r.sdaOe = ack; // R3 R10
						if (!ack) begin
							next_r.st    = ST_IDLE; // R15
							next_r.ackPh = 1'b0;
						end
					end
				end else if (r.ackPh) begin
					// End of the ninth clock: move on to the next byte.
					next_r.ackPh = 1'b0;
					next_r.cnt   = '0;
					next_r.sdaOe = 1'b0;
					if ((r.st == ST_DEV && r.rdMode)
						|| (r.st == ST_RDAT && r.mack)) begin
						next_r.st    = ST_RDAT;
						next_r.sh    = rdByte;
						next_r.sdaOe = ~rdByte[7]; // R3 R4
						// Reads roll over the whole array or the ID page.
						if (r.idSel) begin
							next_r.addr[OFS_W-1:0] =
								r.addr[OFS_W-1:0] + 1'b1;
						end else begin
							next_r.addr = r.addr + 1'b1; // R25
						end
					end else if (r.st == ST_DEV) begin
						next_r.st = ST_AHI; // R16
					end else if (r.st == ST_AHI) begin
						next_r.st = ST_ALO;
					end else if (r.st == ST_ALO) begin
						next_r.st = ST_WDAT;
					end else if (r.st == ST_RDAT) begin
						// No acknowledge from the controller ends the read.
						next_r.st = ST_IDLE;
					end
				end else if (r.st == ST_RDAT && r.cnt != 4'h0) begin
					next_r.sdaOe = ~r.sh[7]; // R3 R4
				end
			end
		end
		next_r.sdaOut  = 1'b0; // R3
		next_r.standby = next_r.st == ST_IDLE; // R11
		next_r.busy    = next_r.st == ST_DRAIN || next_r.st == ST_SWEEP
			|| next_r.st == ST_WAIT; // R17
	end

	// State register.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= REGS_RST; // R11
		end else begin
			r <= next_r;
		end
	end

	// Page buffer fill and the sweep that programs the marked bytes.
	always_ff @(posedge clk) begin
		if (popValid && popReady) begin
			pageBuf[popEnt.ofs] <= popEnt.data;
		end
		if (r.st == ST_SWEEP && r.mask[r.sweep]) begin
			if (r.idSel) begin
				idMem[r.sweep] <= pageBuf[r.sweep]; // R20
			end else begin
				arrayMem[{r.addr[ADDR_W-1:OFS_W], r.sweep}] <=
					pageBuf[r.sweep]; // R19
			end
		end
	end

	assign sdaOut    = r.sdaOut;
	assign sdaOe     = r.sdaOe;
	assign standby   = r.standby;
	assign writeBusy = r.busy;
	assign idLocked  = r.locked;
endmodule : sep_eeprom_slave
`default_nettype wire

/* File: sep_eeprom_slave_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// Checks the slave's outputs against the link's timing rules.
module sep_eeprom_slave_asserts
	import sep_pkg::*;
#(
	parameter int WriteCycles = WRITE_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic standby,
	input wire logic writeBusy,
	input wire logic idLocked
);
	logic [17:0] busyLen;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Length of the current write cycle in clocks.
	always_ff @(posedge clk) begin
		busyLen <= (sys_rst || !writeBusy) ? '0 : busyLen + 18'h1;
	end

	sequence busyRun;
		writeBusy [*8];
	endsequence

	open_drain_a: assert property (sdaOut == 1'b0)
		else $error("data output not held low");
	reset_idle_a: assert property (disable iff (1'b0)
		sys_rst |=> !sdaOe && standby && !writeBusy)
		else $error("outputs not idle after reset");
	busy_silent_a: assert property (writeBusy |-> !sdaOe)
		else $error("bus driven during write cycle");
	drive_awake_a: assert property (sdaOe |-> !standby)
		else $error("bus driven in standby");
	busy_hold_a: assert property ($rose(writeBusy) |-> busyRun)
		else $error("write cycle too short");
	busy_len_a: assert property ($fell(writeBusy) |->
		busyLen >= WriteCycles - 5 && busyLen <= WriteCycles)
		else $error("write cycle length wrong");
	lock_keep_a: assert property (idLocked |=> idLocked)
		else $error("lock flag cleared");
	lock_end_a: assert property ($rose(idLocked) |->
		writeBusy || $past(writeBusy) || $past(writeBusy, 2))
		else $error("lock set outside a write cycle");
endmodule : sep_eeprom_slave_asserts

bind sep_eeprom_slave sep_eeprom_slave_asserts #(
	.WriteCycles(WriteCycles)
) chkr (.clk(clk), .sys_rst(sys_rst), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.standby(standby), .writeBusy(writeBusy), .idLocked(idLocked));
`default_nettype wire

/* File: sep_bus_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// Bus controller model; it only ever pulls the data line low.
module sep_bus_ctrl (
	input  wire logic clk,
	input  wire logic sdaIn,
	output var logic  sclPin,
	output var logic  pullLow
);
	// Both lines released; the clock stands high outside frames.
	initial begin
		sclPin = 1'b1;
		pullLow = 1'b0;
	end

	// One bit: data moves while the clock is low, read late while high.
	task automatic bitx(input logic b, output logic r);
		sclPin <= 1'b0;
		@(posedge clk) pullLow <= ~b;
		repeat (3) @(posedge clk);
		sclPin <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk) r = sdaIn;
		@(posedge clk);
	endtask : bitx

	// Start when isStop is low, stop when high; data moves with clock high.
	task automatic cond(input logic isStop);
		sclPin <= 1'b0;
		@(posedge clk) pullLow <= isStop;
		repeat (5) @(posedge clk);
		sclPin <= 1'b1;
		repeat (4) @(posedge clk);
		pullLow <= ~isStop;
		repeat (4) @(posedge clk);
	endtask : cond

	// Clocks until the data line is seen high, then starts.
	task automatic recover();
		logic r;
		r = 1'b0;
		for (int i = 0; i < 9 && !r; i++) bitx(1'b1, r);
		cond(1'b0);
	endtask : recover

	// Byte goes out most significant bit first; ninth bit returns the ack.
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask : wrByte

	// Reads a byte and acknowledges it when more are wanted.
	task automatic rdByte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(~more, r);
	endtask : rdByte
endmodule : sep_bus_ctrl
`default_nettype wire

/* File: sep_eeprom_slave_bench.sv */
`timescale 1ns/1ps
`default_nettype none

// Runs write, read, protect and ID page sequences through the model.
module sep_eeprom_slave_bench;
	localparam int         WrCycles = 200;
	localparam logic [2:0] Sel      = 3'h5;
	localparam logic [7:0] Dev      = {4'ha, Sel, 1'b0};
	localparam logic [7:0] Id       = {4'hb, Sel, 1'b0};

	logic       clk, sys_rst, sclPin, pullLow, sdaIn, sdaOut, sdaOe;
	logic       standby, writeBusy, idLocked, writeProtect;
	logic [2:0] cs;
	logic [7:0] d;
	int         fails, compares, cycles;

	// Open-drain wire with a pull-up; the slave's level counts when enabled.
	assign sdaIn = ~pullLow & (~sdaOe | sdaOut);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	sep_bus_ctrl ctl (.clk(clk), .sdaIn(sdaIn), .sclPin(sclPin),
		.pullLow(pullLow));
	sep_eeprom_slave #(.WriteCycles(WrCycles)) DUT (
		.clk(clk), .sys_rst(sys_rst), .sclPin(sclPin), .sdaIn(sdaIn),
		.chipSelectBit2(cs[2]), .chipSelectBit1(cs[1]),
		.chipSelectBit0(cs[0]), .writeProtect(writeProtect),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .standby(standby),
		.writeBusy(writeBusy), .idLocked(idLocked));

	// Cuts a hang short.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fails++;
			end_sim();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic send(input logic [7:0] b, input logic exp);
		logic k;
		ctl.wrByte(b, k);
		chk({7'h0, k}, {7'h0, exp});
	endtask : send

	// Start, address word and both word-address bytes.
	task automatic addr(input logic [7:0] dev, input logic [15:0] a);
		ctl.cond(1'b0);
		send(dev, 1'b1);
		send(a[15:8], 1'b1);
		send(a[7:0], 1'b1);
	endtask : addr

	// Random read of one or two bytes, then stop into standby.
	task automatic rdAt(input logic [7:0] dev, input logic [15:0] a,
		input logic [7:0] exp, input logic two);
		addr(dev, a);
		ctl.cond(1'b0);
		send(dev | 8'h01, 1'b1);
		ctl.rdByte(two, d);
		chk(d, exp);
		if (two) begin
			ctl.rdByte(1'b0, d);
			chk(d, exp + 8'h01);
		end
		ctl.cond(1'b1);
		repeat (2) @(posedge clk);
		chk({7'h0, standby}, 8'h01);
	endtask : rdAt

	task automatic idle();
		for (int i = 0; i < 400 && writeBusy !== 1'b0; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		chk({7'h0, writeBusy}, 8'h00);
	endtask : idle

	task automatic end_sim();
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	initial begin
		sys_rst = 1'b1;
		cs = Sel;
		writeProtect = 1'b0;
		fails = 0;
		compares = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clk);
		chk({7'h0, standby}, 8'h01);
		ctl.recover();
		send({4'h5, Sel, 1'b0}, 1'b0);
		// Only the strapped select value answers.
		for (int s = 0; s < 8; s++) begin
			ctl.cond(1'b0);
			send({4'ha, s[2:0], 1'b0}, s[2:0] == Sel);
		end
		ctl.cond(1'b1);
		// Restrapping every select pin moves the device to the new value.
		cs <= ~Sel;
		repeat (4) @(posedge clk);
		ctl.cond(1'b0);
		send(Dev, 1'b0);
		ctl.cond(1'b0);
		send({4'ha, ~Sel, 1'b0}, 1'b1);
		ctl.cond(1'b1);
		cs <= Sel;
		repeat (4) @(posedge clk);
		// Page write from offset 3e wraps to the start of the page.
		addr(Dev, 16'h927e);
		for (int i = 0; i < 4; i++) send(8'h10 + i[7:0], 1'b1);
		ctl.cond(1'b1);
		repeat (5) @(posedge clk);
		chk({7'h0, writeBusy}, 8'h01);
		ctl.cond(1'b0);
		send(Dev, 1'b0);
		idle();
		ctl.cond(1'b0);
		send(Dev, 1'b1);
		ctl.cond(1'b1);
		rdAt(Dev, 16'h127e, 8'h10, 1'b1);
		rdAt(Dev, 16'h1240, 8'h12, 1'b0);
		ctl.cond(1'b0);
		send(Dev | 8'h01, 1'b1);
		ctl.rdByte(1'b0, d);
		chk(d, 8'h13);
		ctl.cond(1'b1);
		// Protected array write is refused and starts no cycle.
		writeProtect <= 1'b1;
		addr(Dev, 16'h1240);
		send(8'h55, 1'b0);
		ctl.cond(1'b1);
		repeat (9) @(posedge clk);
		chk({7'h0, writeBusy}, 8'h00);
		writeProtect <= 1'b0;
		rdAt(Dev, 16'h1240, 8'h12, 1'b0);
		// ID page write, lock, then a refused write.
		addr(Id, 16'hfbc5);
		send(8'h77, 1'b1);
		ctl.cond(1'b1);
		idle();
		rdAt(Id, 16'h0005, 8'h77, 1'b0);
		// A lock byte with bit 1 clear is taken but starts nothing.
		addr(Id, 16'h0400);
		send(8'hfd, 1'b1);
		ctl.cond(1'b1);
		repeat (9) @(posedge clk);
		chk({7'h0, writeBusy}, 8'h00);
		chk({7'h0, idLocked}, 8'h00);
		addr(Id, 16'h0400);
		send(8'h02, 1'b1);
		ctl.cond(1'b1);
		idle();
		chk({7'h0, idLocked}, 8'h01);
		addr(Id, 16'h0005);
		send(8'h99, 1'b0);
		ctl.cond(1'b1);
		rdAt(Id, 16'h0005, 8'h77, 1'b0);
		end_sim();
	end
endmodule : sep_eeprom_slave_bench
`default_nettype wire
